// file: rtl/clk_path_pkg.sv
// package: register map, field layout and codes for the input clock paths
package clk_path_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [9:0] OFF_CRYSTAL_PATH_CONFIG = 10'h300;
  localparam logic [9:0] OFF_CRYSTAL_AMP_STRENGTH = 10'h301;
  localparam logic [9:0] OFF_CRYSTAL_LOAD_CAPS = 10'h302;
  localparam logic [9:0] OFF_INPUT1_PATH_CONFIG = 10'h303;
  localparam logic [9:0] OFF_INPUT2_PATH_CONFIG = 10'h304;
  localparam logic [9:0] OFF_INPUT3_PATH_CONFIG = 10'h305;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int INVERT_BIT = 6;
  localparam int PRESCALE_LSB = 0;
  localparam int CAP_A_LSB = 0;
  localparam int CAP_B_LSB = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int NUM_PATHS = 4;
  localparam logic [2:0] IDX_UNMAPPED = 3'h7;
  localparam logic [2:0] IDX_AMP = 3'h4;
  localparam logic [2:0] IDX_CAPS = 3'h5;

  // ----------------------------------------------------------------
  // prescale codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  localparam logic [1:0] DIV8 = 2'h3;

  // per-path configuration held by the block
  typedef struct packed {
    logic input_invert;
    logic [1:0] input_prescale;
  } path_cfg_t;

  // one register access request
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [9:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one less than the edges between output toggles for a prescale code (div 1 unused)
  function automatic logic [1:0] toggle_limit(input logic [1:0] code);
    unique case (code)
      DIV2: toggle_limit = 2'h0;
      DIV4: toggle_limit = 2'h1;
      DIV8: toggle_limit = 2'h3;
      default: toggle_limit = 2'h0;
    endcase
  endfunction

endpackage

// file: rtl/clk_prescaler.sv
// module: one input clock path with polarity select and prescaler
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler
  import clk_path_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // path input and settings
  input wire logic clk_in,
  input wire logic input_invert,
  input wire logic [1:0] input_prescale,
  // prescaled clock
  output logic clk_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic pol_clk; // input after polarity select
  logic prev_r; // last polarity-corrected sample
  logic prev_nxt;
  logic [1:0] cnt_r; // rising edges since last toggle
  logic [1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic rise; // rising edge of the corrected input

  // polarity select sits ahead of the divider
  assign pol_clk = clk_in ^ input_invert;
  assign rise = pol_clk & ~prev_r;

  // next state: pass through or toggle on counted edges
  always_comb
  begin
    prev_nxt = pol_clk;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (input_prescale == DIV1)
    begin
      // undivided, one cycle of latency
      out_nxt = pol_clk;
      cnt_nxt = 2'h0;
    end
    else if (rise)
    begin
      // half a divided period has passed
      if (cnt_r >= toggle_limit(input_prescale))
      begin
        out_nxt = ~out_r;
        cnt_nxt = 2'h0;
      end
      else
      begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_r <= 1'b0;
      cnt_r <= 2'h0;
      out_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pass_through_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (input_prescale == DIV1) |=> (clk_out == $past(pol_clk)))
    else $error("undivided path does not follow corrected input");

  toggle_on_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($past(input_prescale) != DIV1 && $changed(clk_out)) |-> $past(rise))
    else $error("divided clock toggled without an input rising edge");

  // the bound is the one in force when the count was made, so a ratio
  // change on the next edge cannot trip it; a count left high by a switch
  // to a smaller ratio is caught by the toggle at the next rising edge
  count_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (input_prescale != DIV1 && cnt_r <= toggle_limit(input_prescale))
      |=> (cnt_r <= toggle_limit($past(input_prescale))))
    else $error("prescale edge count ran past its limit");

endmodule
`default_nettype wire

// file: rtl/input_clock_path_config.sv
// module: input clock path configuration registers and four clock paths
`timescale 1ns/1ps
`default_nettype none
module input_clock_path_config
  import clk_path_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register access port
  input wire clk_path_pkg::reg_req_t reg_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // clock inputs, sampled on clk_sys
  input wire logic crystal_pin_a,
  input wire logic [2:0] clock_input,
  // prescaled clocks toward the output banks
  output logic crystal_clk_out,
  output logic [2:0] input_clk_out,
  // crystal driver settings
  output logic [7:0] osc_amp_strength,
  output logic [3:0] crystal_pin_a_cap,
  output logic [3:0] crystal_pin_b_cap
);

  import clk_path_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // path configs map to index 0..3, amp 4, caps 5, else unmapped
  function automatic logic [2:0] reg_index(input logic [9:0] addr);
    unique case (addr)
      OFF_CRYSTAL_PATH_CONFIG: reg_index = 3'h0;
      OFF_INPUT1_PATH_CONFIG: reg_index = 3'h1;
      OFF_INPUT2_PATH_CONFIG: reg_index = 3'h2;
      OFF_INPUT3_PATH_CONFIG: reg_index = 3'h3;
      OFF_CRYSTAL_AMP_STRENGTH: reg_index = IDX_AMP;
      OFF_CRYSTAL_LOAD_CAPS: reg_index = IDX_CAPS;
      default: reg_index = IDX_UNMAPPED;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  path_cfg_t cfg_r [NUM_PATHS]; // 0 crystal, 1..3 other inputs
  path_cfg_t cfg_nxt [NUM_PATHS];
  logic [7:0] amp_r; // amplifier control, passed straight out
  logic [7:0] amp_nxt;
  logic [7:0] caps_r; // load capacitor pair
  logic [7:0] caps_nxt;
  logic [7:0] rd_data_r; // read answer
  logic [7:0] rd_data_nxt;
  logic rd_valid_r; // one-cycle answer strobe
  logic rd_valid_nxt;
  logic [2:0] wr_idx; // decoded write target
  logic [2:0] rd_idx; // decoded read target

  assign wr_idx = reg_index(reg_req.addr);
  assign rd_idx = wr_idx;

  // next register values from the access port
  always_comb
  begin
    for (int i = 0; i < NUM_PATHS; i++)
    begin
      cfg_nxt[i] = cfg_r[i];
    end
    amp_nxt = amp_r;
    caps_nxt = caps_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = reg_req.rd_en;
    if (reg_req.wr_en)
    begin
      if (wr_idx < IDX_AMP)
      begin
        // only the documented fields are stored; the rest stay zero
        cfg_nxt[wr_idx[1:0]].input_invert = reg_req.wdata[INVERT_BIT];
        cfg_nxt[wr_idx[1:0]].input_prescale =
          reg_req.wdata[PRESCALE_LSB +: 2];
      end
      else if (wr_idx == IDX_AMP)
      begin
        // value is chosen by software from its crystal table
        amp_nxt = reg_req.wdata;
      end
      else if (wr_idx == IDX_CAPS)
      begin
        caps_nxt = reg_req.wdata;
      end
    end
    if (reg_req.rd_en)
    begin
      // reads see the value before a same-cycle write
      if (rd_idx < IDX_AMP)
      begin
        rd_data_nxt = RESET_BYTE;
        rd_data_nxt[INVERT_BIT] = cfg_r[rd_idx[1:0]].input_invert;
        rd_data_nxt[PRESCALE_LSB +: 2] = cfg_r[rd_idx[1:0]].input_prescale;
      end
      else if (rd_idx == IDX_AMP)
      begin
        rd_data_nxt = amp_r;
      end
      else if (rd_idx == IDX_CAPS)
      begin
        rd_data_nxt = caps_r;
      end
      else
      begin
        // unmapped addresses read as zero
        rd_data_nxt = RESET_BYTE;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_PATHS; i++)
      begin
        cfg_r[i] <= '0;
      end
      amp_r <= RESET_BYTE;
      caps_r <= RESET_BYTE;
      rd_data_r <= RESET_BYTE;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_PATHS; i++)
      begin
        cfg_r[i] <= cfg_nxt[i];
      end
      amp_r <= amp_nxt;
      caps_r <= caps_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign osc_amp_strength = amp_r;
  // upper nibble drives pin b, lower nibble pin a
  assign crystal_pin_b_cap = caps_r[CAP_B_LSB +: 4];
  assign crystal_pin_a_cap = caps_r[CAP_A_LSB +: 4];

  // ----------------------------------------------------------------
  // clock paths
  // ----------------------------------------------------------------
  logic [3:0] path_in; // raw path inputs, crystal first
  logic [3:0] path_out; // prescaled path outputs
  logic [1:0] ratio [NUM_PATHS]; // effective prescale code per path

  assign path_in = {clock_input, crystal_pin_a};

  // crystal path has only two legal codes; the unused ones fall back
  // to undivided so a stray write cannot leave the path undefined
  always_comb
  begin
    for (int i = 0; i < NUM_PATHS; i++)
    begin
      ratio[i] = cfg_r[i].input_prescale;
    end
    ratio[0] = (cfg_r[0].input_prescale == DIV2) ? DIV2 : DIV1;
  end

  for (genvar g = 0; g < NUM_PATHS; g++)
  begin : g_path
    clk_prescaler clk_prescaler_i (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_in(path_in[g]),
      .input_invert(cfg_r[g].input_invert),
      .input_prescale(ratio[g]),
      .clk_out(path_out[g])
    );
  end

  assign crystal_clk_out = path_out[0];
  assign input_clk_out = path_out[3:1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  crystal_code_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_req.wr_en && reg_req.addr == OFF_CRYSTAL_PATH_CONFIG)
      |=> (ratio[0] == (($past(reg_req.wdata[1:0]) == DIV2) ? DIV2 : DIV1)))
    else $error("crystal prescale code not mapped to divide 1 or 2");

  load_cap_split_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_req.wr_en && reg_req.addr == OFF_CRYSTAL_LOAD_CAPS)
      |=> (crystal_pin_b_cap == $past(reg_req.wdata[7:4])
        && crystal_pin_a_cap == $past(reg_req.wdata[3:0])))
    else $error("load capacitor nibbles not split to pins b and a");

  invert_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_req.wr_en && reg_req.addr == OFF_INPUT2_PATH_CONFIG)
      |=> (cfg_r[2].input_invert == $past(reg_req.wdata[6])))
    else $error("polarity bit not taken from bit 6");

  input_prescale_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_req.wr_en && reg_req.addr == OFF_INPUT3_PATH_CONFIG)
      |=> (ratio[3] == $past(reg_req.wdata[1:0])))
    else $error("input prescale code not applied as written");

  read_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (reg_req.rd_en && reg_index(reg_req.addr) == IDX_UNMAPPED)
      |=> (rd_valid && rd_data == RESET_BYTE))
    else $error("unmapped read did not answer zero");

endmodule
`default_nettype wire

// file: verification/tb_input_clock_path_config.sv
// testbench: register access and clock path checks for the input clock block
`timescale 1ns/1ps
`default_nettype none
module tb_input_clock_path_config;
  import clk_path_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0; // 100 MHz system clock
  logic reset_n = 1'b0; // held low at start
  reg_req_t req = '0; // register request
  logic inw = 1'b0; // one waveform fed to every clock input
  logic [7:0] rd_data;
  logic rd_valid;
  logic crystal_clk_out;
  logic [2:0] input_clk_out;
  logic [7:0] osc_amp_strength;
  logic [3:0] crystal_pin_a_cap;
  logic [3:0] crystal_pin_b_cap;
  logic [3:0] outs; // crystal path in bit 0
  logic [7:0] rv; // last read answer
  int err_total = 0;
  int cmp_count = 0;
  assign outs = {input_clk_out, crystal_clk_out};
  // clock toggles every half period
  always #5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  input_clock_path_config input_clock_path_config_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_req(req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .crystal_pin_a(inw),
    .clock_input({3{inw}}),
    .crystal_clk_out(crystal_clk_out),
    .input_clk_out(input_clk_out),
    .osc_amp_strength(osc_amp_strength),
    .crystal_pin_a_cap(crystal_pin_a_cap),
    .crystal_pin_b_cap(crystal_pin_b_cap)
  );
  // ----------------------------------------------------------------
  // case tables
  // ----------------------------------------------------------------
  // register rows: address, written byte, expected readback
  typedef struct packed {logic [9:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [8] = '{'{10'h300, 8'hFF, 8'h43}, '{10'h301, 8'h50, 8'h50},
    '{10'h302, 8'hA5, 8'hA5}, '{10'h303, 8'hC7, 8'h43}, '{10'h304, 8'hBE, 8'h02},
    '{10'h305, 8'h3D, 8'h01}, '{10'h306, 8'h5A, 8'h00}, '{10'h2FF, 8'h77, 8'h00}};
  // clock rows: path, config byte, output toggles over 16 input periods
  typedef struct packed {logic [1:0] p; logic [7:0] c; logic [5:0] n;} pcase_t;
  pcase_t pcs [13] = '{'{2'd0, 8'h00, 6'd32}, '{2'd0, 8'h01, 6'd16},
    '{2'd0, 8'h02, 6'd32}, '{2'd0, 8'h43, 6'd32}, '{2'd0, 8'h41, 6'd16},
    '{2'd0, 8'h40, 6'd32}, '{2'd1, 8'h00, 6'd32}, '{2'd1, 8'h01, 6'd16},
    '{2'd1, 8'h02, 6'd8}, '{2'd1, 8'h03, 6'd4}, '{2'd2, 8'h42, 6'd8},
    '{2'd3, 8'h43, 6'd4}, '{2'd3, 8'h40, 6'd32}};
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // counts, verdict, end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one write strobe; an idle edge first so req never changes twice at once
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req = '0;
  endtask
  // one read strobe; answer lands one cycle later as a single pulse
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    #1 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1 req = '0;
    chk("rd_valid", rd_valid, 1'b1);
    rv = rd_data;
    @(posedge clk_sys);
    #1 chk("rd_valid low", rd_valid, 1'b0);
  endtask
  // configure a path, run 16 slow input periods, count output toggles
  task automatic path_run(input logic [1:0] p, input logic [7:0] cfg, input int exp);
    logic prev;
    int cnt;
    cnt = 0;
    wr(OFF_CRYSTAL_PATH_CONFIG + (p == 2'd0 ? 10'h0 : 10'(p) + 10'h2), cfg);
    // settle time covers the edge made by a polarity change
    repeat (4) @(posedge clk_sys);
    #1 prev = outs[p];
    for (int i = 0; i < 134; i++)
    begin
      @(posedge clk_sys);
      #1 inw = ((i % 8) >= 4) && (i < 128);
      if (outs[p] !== prev)
        cnt++;
      prev = outs[p];
    end
    chk("toggles", cnt, exp);
    // undivided path idles at the corrected input level
    if (exp == 32)
      chk("idle level", outs[p], cfg[6]);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    chk("amp in reset", osc_amp_strength, 8'h00);
    #1 reset_n = 1'b1;
    // reset values, unmapped 0x306 included
    for (int a = 0; a < 7; a++)
    begin
      rd(OFF_CRYSTAL_PATH_CONFIG + 10'(a));
      chk("reset value", rv, RESET_BYTE);
    end
    // ordinary rows: masked fields, unmapped places ignored
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", rv, rows[i].e);
    end
    chk("amp out", osc_amp_strength, 8'h50);
    chk("cap a", crystal_pin_a_cap, 4'h5);
    chk("cap b", crystal_pin_b_cap, 4'hA);
    // read and write of one place in one cycle returns the old byte
    @(posedge clk_sys);
    #1 req = '{wr_en: 1'b1, rd_en: 1'b1, addr: OFF_CRYSTAL_AMP_STRENGTH, wdata: 8'h98};
    @(posedge clk_sys);
    #1 req = '0;
    chk("old value", rd_data, 8'h50);
    rd(OFF_CRYSTAL_AMP_STRENGTH);
    chk("new value", rv, 8'h98);
    // reset in mid-run clears settings at once
    reset_n = 1'b0;
    #2 chk("amp cleared", osc_amp_strength, 8'h00);
    chk("cap b cleared", crystal_pin_b_cap, 4'h0);
    @(posedge clk_sys);
    #1 reset_n = 1'b1;
    rd(OFF_CRYSTAL_LOAD_CAPS);
    chk("caps after reset", rv, 8'h00);
    // every prescale code and polarity on each kind of path
    foreach (pcs[i])
      path_run(pcs[i].p, pcs[i].c, int'(pcs[i].n));
    report_and_stop();
  end
  // watchdog: a hang counts as a mismatch
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
